// ==== hw/eles_classifier.sv ====
`timescale 1ns/1ps
`default_nettype none
module eles_classifier
  import eles_pkg::*;
(
  eles_cls_if.classifier cls
);

  always_comb begin
    cls.halt  = 1'b0;
    cls.known = 1'b1;
    cls.led   = LED_OFF;
    unique case (cls.code)
      CODE_PROG_DAMAGED, CODE_MEM_DENIED, CODE_EXT_MEM_DENIED: begin
        cls.halt = 1'b1;
        cls.led  = LED_NORMAL;
      end
      CODE_PROG_LOG_MISM, CODE_CARD_PLACEMENT: begin
        cls.halt = 1'b1;
        cls.led  = LED_NORMAL;
      end
      CODE_IRQ_RANGE, CODE_MASTER_CTRL_RANGE, CODE_MASTER_RESET_RANGE: begin
        cls.halt = 1'b1;
        cls.led  = LED_NORMAL;
      end
      CODE_HSC_OPERAND, CODE_CNT_OPERAND: begin
        cls.halt = 1'b1;
        cls.led  = LED_NORMAL;
      end
      CODE_BAD_ID, CODE_BAD_PASSWORD, CODE_PWD_LIMIT: begin
        cls.led = LED_OFF;
      end
      CODE_CARD_ABSENT, CODE_CARD_INIT, CODE_CARD_WRITE, CODE_CARD_READ: begin
        cls.led = LED_OFF;
      end
      CODE_SUPPLY_DIP: begin
        cls.led = LED_FAST;
      end
      CODE_CLOCK_LOST, CODE_BATTERY_LOW: begin
        cls.led = LED_OFF;
      end
      default: begin
        if (cls.code >= CODE_LATCH_FIRST && cls.code <= CODE_LATCH_LAST) begin
          cls.led = LED_OFF;
        end else if (cls.code >= CODE_REMOTE_FIRST
                     && cls.code <= CODE_REMOTE_LAST) begin
          cls.led = LED_SLOW;
        end else begin
          // unlisted codes raise the unknown flag but change nothing else
          cls.known = 1'b0;
        end
      end
    endcase
  end

endmodule
`default_nettype wire

// ==== hw/eles_top.sv ====
// Summary of operation
// - each detected fault presents a numeric code with a strobe to this encoder
// - the LED has five states: on, off, fast, normal and slow blinking
// - fast blinking toggles the LED with a 0.2 second period
// - normal blinking toggles the LED with a 0.5 second period
// - slow blinking is lit 1 second then dark 3 seconds, repeating
// - steady on is for serious errors; each code halts or continues
// - while LED is on, fast or normal, processor run stays blocked until clear
// - halting codes stop execution, continuing codes leave it alone
// - codes 000C, 0010, 002E halt with normal blinking
// - codes 002F and 0070 halt with normal blinking
// - codes 0102, 0202, 0302 halt with normal blinking
// - codes 0D03 and 0E05 halt with normal blinking
// - codes 0011, 0012, 002D continue with LED off
// - codes 0050 through 0059 continue with LED off
// - codes 005D, 005E, 0063, 0064 continue with LED off
// - code 002A continues with fast blinking
// - codes 0026 and 0027 continue and set no LED state
// - codes 1300 through 130F continue with slow blinking
`timescale 1ns/1ps
`default_nettype none
module eles_top
  import eles_pkg::*;
#(
  parameter int unsigned MS_CYCLES = MS_TICK_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        errValid,
  input  wire logic [15:0] errCode,
  input  wire logic        serious,
  input  wire logic        clearErr,
  output logic             errLed,
  output logic             cpuHalt,
  output logic             runPermit,
  output logic [2:0]       ledState,
  output logic             unknownCode
);

  // ----------------------------------------------------------------
  // code classification
  // ----------------------------------------------------------------
  eles_cls_if cls ();

  assign cls.code = errCode;

  eles_classifier u_cls (
    .cls (cls)
  );

  // ----------------------------------------------------------------
  // accumulated error state
  // ----------------------------------------------------------------
  // most severe state seen since the last clear, and halt latch
  eles_led_type sevQ;
  eles_led_type sevD;
  logic         haltQ;
  logic         haltD;
  logic         unknownQ;

  always_comb begin
    sevD  = sevQ;
    haltD = haltQ;
    if (clearErr) begin
      sevD  = LED_OFF;
      haltD = 1'b0;
    end
    // a new code in the clear cycle still lands: set beats clear
    if (serious) begin
      sevD  = LED_ON;
      haltD = 1'b1;
    end
    if (errValid) begin
      if (cls.led > sevD) begin
        sevD = cls.led;
      end
      if (cls.halt) begin
        haltD = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sevQ  <= LED_OFF;
      haltQ <= 1'b0;
    end else begin
      sevQ  <= sevD;
      haltQ <= haltD;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      unknownQ <= 1'b0;
    end else if (errValid && !cls.known) begin
      unknownQ <= 1'b1;
    end else if (clearErr) begin
      unknownQ <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // millisecond tick
  // ----------------------------------------------------------------
  localparam int unsigned TICK_W = $clog2(MS_CYCLES + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(MS_CYCLES - 1);

  logic [TICK_W-1:0] tickCntQ;
  logic              msTickQ;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tickCntQ <= '0;
      msTickQ  <= 1'b0;
    end else if (tickCntQ == TICK_LAST) begin
      tickCntQ <= '0;
      msTickQ  <= 1'b1;
    end else begin
      tickCntQ <= tickCntQ + TICK_W'(1);
      msTickQ  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // blink generators
  // ----------------------------------------------------------------
  // free running; a fresh state picks up mid-phase, at most one half
  // period late (slow: up to its 3 second dark phase), which keeps the generators simple
  localparam logic [11:0] FAST_HALF   = 12'(FAST_HALF_MS - 1);
  localparam logic [11:0] NORMAL_HALF = 12'(NORMAL_HALF_MS - 1);
  localparam logic [11:0] SLOW_LAST   = 12'(SLOW_ON_MS + SLOW_OFF_MS - 1);
  localparam logic [11:0] SLOW_ON_END = 12'(SLOW_ON_MS);

  logic [11:0] fastCntQ;
  logic [11:0] normCntQ;
  logic [11:0] slowCntQ;
  logic        fastQ;
  logic        normQ;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fastCntQ <= '0;
      fastQ    <= 1'b0;
    end else if (msTickQ) begin
      if (fastCntQ == FAST_HALF) begin
        fastCntQ <= '0;
        fastQ    <= ~fastQ;
      end else begin
        fastCntQ <= fastCntQ + 12'h001;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      normCntQ <= '0;
      normQ    <= 1'b0;
    end else if (msTickQ) begin
      if (normCntQ == NORMAL_HALF) begin
        normCntQ <= '0;
        normQ    <= ~normQ;
      end else begin
        normCntQ <= normCntQ + 12'h001;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      slowCntQ <= '0;
    end else if (msTickQ) begin
      if (slowCntQ == SLOW_LAST) begin
        slowCntQ <= '0;
      end else begin
        slowCntQ <= slowCntQ + 12'h001;
      end
    end
  end

  logic slowLit;
  assign slowLit = (slowCntQ < SLOW_ON_END);

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic ledD;

  always_comb begin
    unique case (sevQ)
      LED_OFF:    ledD = 1'b0;
      LED_SLOW:   ledD = slowLit;
      LED_NORMAL: ledD = normQ;
      LED_FAST:   ledD = fastQ;
      LED_ON:     ledD = 1'b1;
      default:    ledD = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      errLed      <= 1'b0;
      cpuHalt     <= 1'b0;
      runPermit   <= 1'b1;
      ledState    <= 3'h0;
      unknownCode <= 1'b0;
    end else begin
      errLed      <= ledD;
      cpuHalt     <= haltQ;
      // run blocked for on, fast and normal until cleared
      runPermit   <= !haltQ && (sevQ < LED_NORMAL);
      ledState    <= sevQ;
      unknownCode <= unknownQ;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_halt_codes_stop: assert property (@(posedge mclk) disable iff (rst)
    errValid && !clearErr && (errCode == CODE_MEM_DENIED) |-> ##2 cpuHalt && !runPermit)
    else $error("halting code did not stop the processor");

  a_remote_slow: assert property (@(posedge mclk) disable iff (rst)
    errValid && (errCode == CODE_REMOTE_LAST) |=> sevQ >= LED_SLOW)
    else $error("remote code did not select slow blinking");

  a_dip_fast: assert property (@(posedge mclk) disable iff (rst)
    errValid && !serious && (errCode == CODE_SUPPLY_DIP) && !haltQ |=> sevQ >= LED_FAST)
    else $error("supply dip did not select fast blinking");

  a_card_continue: assert property (@(posedge mclk) disable iff (rst)
    errValid && !serious && !clearErr && (errCode == CODE_CARD_READ) |=> $stable(haltQ) && $stable(sevQ))
    else $error("memory card fault stopped the processor");

  a_run_blocked: assert property (@(posedge mclk) disable iff (rst)
    (sevQ >= LED_NORMAL) |=> !runPermit)
    else $error("processor allowed to run while error LED active");

  a_severity_keep: assert property (@(posedge mclk) disable iff (rst)
    !clearErr && (sevQ == LED_FAST) |=> sevQ >= LED_FAST)
    else $error("less severe code lowered the LED state");

  a_steady_on: assert property (@(posedge mclk) disable iff (rst)
    (sevQ == LED_ON) && $past(sevQ == LED_ON) |=> errLed)
    else $error("steady on state did not light the LED");

  a_led_off: assert property (@(posedge mclk) disable iff (rst)
    (sevQ == LED_OFF) |=> !errLed)
    else $error("LED lit while in the off state");

  a_slow_phase: assert property (@(posedge mclk) disable iff (rst)
    msTickQ && (slowCntQ == SLOW_LAST) |=> slowLit ##1 slowLit)
    else $error("slow blink did not restart in its lit phase");

  a_tick_align: assert property (@(posedge mclk) disable iff (rst)
    msTickQ |-> (tickCntQ == '0))
    else $error("millisecond tick out of step with its counter");

  a_fast_toggle: assert property (@(posedge mclk) disable iff (rst)
    msTickQ && (fastCntQ == FAST_HALF) |=> (fastQ != $past(fastQ)))
    else $error("fast blink did not toggle at its half period");

  a_fast_hold: assert property (@(posedge mclk) disable iff (rst)
    !(msTickQ && (fastCntQ == FAST_HALF)) |=> $stable(fastQ))
    else $error("fast blink toggled inside its half period");

  a_norm_toggle: assert property (@(posedge mclk) disable iff (rst)
    msTickQ && (normCntQ == NORMAL_HALF) |=> (normQ != $past(normQ)))
    else $error("normal blink did not toggle at its half period");

  a_norm_hold: assert property (@(posedge mclk) disable iff (rst)
    !(msTickQ && (normCntQ == NORMAL_HALF)) |=> $stable(normQ))
    else $error("normal blink toggled inside its half period");

  a_slow_dark: assert property (@(posedge mclk) disable iff (rst)
    msTickQ && (slowCntQ == SLOW_ON_END - 12'h001) |=> !slowLit)
    else $error("slow blink did not go dark after its lit phase");

  a_serious_on: assert property (@(posedge mclk) disable iff (rst)
    serious |=> haltQ && (sevQ == LED_ON))
    else $error("serious error did not halt with steady on");

  a_clear_release: assert property (@(posedge mclk) disable iff (rst)
    clearErr && !errValid && !serious |=> ##1 runPermit && !cpuHalt)
    else $error("clear did not release the processor");

  a_placement_halt: assert property (@(posedge mclk) disable iff (rst)
    errValid && (errCode == CODE_CARD_PLACEMENT) |=> haltQ && (sevQ >= LED_NORMAL))
    else $error("placement mismatch did not halt the processor");

  a_range_halt: assert property (@(posedge mclk) disable iff (rst)
    errValid && (errCode == CODE_MASTER_CTRL_RANGE) |=> haltQ && (sevQ >= LED_NORMAL))
    else $error("range error did not halt the processor");

  a_operand_halt: assert property (@(posedge mclk) disable iff (rst)
    errValid && (errCode == CODE_CNT_OPERAND) |=> haltQ && (sevQ >= LED_NORMAL))
    else $error("operand misuse did not halt the processor");

  a_password_continue: assert property (@(posedge mclk) disable iff (rst)
    errValid && !serious && !clearErr && (errCode == CODE_BAD_PASSWORD)
    |=> $stable(haltQ) && $stable(sevQ))
    else $error("password fault changed the run state");

  a_latch_continue: assert property (@(posedge mclk) disable iff (rst)
    errValid && !serious && !clearErr && (errCode >= CODE_LATCH_FIRST)
    && (errCode <= CODE_LATCH_LAST) |=> $stable(haltQ) && $stable(sevQ))
    else $error("retentive storage fault changed the run state");

  a_battery_continue: assert property (@(posedge mclk) disable iff (rst)
    errValid && !serious && !clearErr
    && ((errCode == CODE_CLOCK_LOST) || (errCode == CODE_BATTERY_LOW))
    |=> $stable(haltQ) && $stable(sevQ))
    else $error("clock or battery fault changed the run state");

  a_unknown_flag: assert property (@(posedge mclk) disable iff (rst)
    errValid && (errCode == 16'hFFFF) |=> ##1 unknownCode)
    else $error("unlisted code did not raise the unknown flag");

endmodule
`default_nettype wire

// ==== include/eles_cls_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface eles_cls_if;
  logic [15:0]  code;
  logic         halt;
  logic         known;
  eles_pkg::eles_led_type led;

  modport classifier (input code, output halt, output known, output led);
  modport user (output code, input halt, input known, input led);
endinterface
`default_nettype wire

// ==== include/eles_pkg.sv ====
`default_nettype none
package eles_pkg;

  localparam int unsigned CLK_HZ = 10_000_000;

  // blink timing, figures in milliseconds
  localparam int unsigned FAST_PERIOD_MS   = 200;
  localparam int unsigned NORMAL_PERIOD_MS = 500;
  localparam int unsigned SLOW_ON_MS       = 1000;
  localparam int unsigned SLOW_OFF_MS      = 3000;

  // one tick per millisecond drives all blink counters
  localparam int unsigned MS_TICK_CYCLES = CLK_HZ / 1000;

  // toggle every half period
  localparam int unsigned FAST_HALF_MS   = FAST_PERIOD_MS / 2;
  localparam int unsigned NORMAL_HALF_MS = NORMAL_PERIOD_MS / 2;

  localparam logic [15:0] CODE_PROG_DAMAGED   = 16'h000C;
  localparam logic [15:0] CODE_MEM_DENIED     = 16'h0010;
  localparam logic [15:0] CODE_BAD_ID         = 16'h0011;
  localparam logic [15:0] CODE_BAD_PASSWORD   = 16'h0012;
  localparam logic [15:0] CODE_CLOCK_LOST     = 16'h0026;
  localparam logic [15:0] CODE_BATTERY_LOW    = 16'h0027;
  localparam logic [15:0] CODE_SUPPLY_DIP     = 16'h002A;
  localparam logic [15:0] CODE_PWD_LIMIT      = 16'h002D;
  localparam logic [15:0] CODE_EXT_MEM_DENIED = 16'h002E;
  localparam logic [15:0] CODE_PROG_LOG_MISM  = 16'h002F;
  localparam logic [15:0] CODE_LATCH_FIRST    = 16'h0050;
  localparam logic [15:0] CODE_LATCH_LAST     = 16'h0059;
  localparam logic [15:0] CODE_CARD_ABSENT    = 16'h005D;
  localparam logic [15:0] CODE_CARD_INIT      = 16'h005E;
  localparam logic [15:0] CODE_CARD_WRITE     = 16'h0063;
  localparam logic [15:0] CODE_CARD_READ      = 16'h0064;
  localparam logic [15:0] CODE_CARD_PLACEMENT = 16'h0070;
  localparam logic [15:0] CODE_IRQ_RANGE      = 16'h0102;
  localparam logic [15:0] CODE_MASTER_CTRL_RANGE  = 16'h0202;
  localparam logic [15:0] CODE_MASTER_RESET_RANGE = 16'h0302;
  localparam logic [15:0] CODE_HSC_OPERAND    = 16'h0D03;
  localparam logic [15:0] CODE_CNT_OPERAND    = 16'h0E05;
  localparam logic [15:0] CODE_REMOTE_FIRST   = 16'h1300;
  localparam logic [15:0] CODE_REMOTE_LAST    = 16'h130F;

  // listed in rising severity so a larger value wins
  typedef enum logic [2:0] {
    LED_OFF,
    LED_SLOW,
    LED_NORMAL,
    LED_FAST,
    LED_ON
  } eles_led_type;

endpackage
`default_nettype wire

// ==== tb/eles_led_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module eles_led_model (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        errLed,
  output logic [31:0]      hiLen,
  output logic [31:0]      loLen,
  output logic [31:0]      toggles
);
  logic        prevLed;
  logic [31:0] runLen;

  // ---------------------------------------------------------------
  // front-panel lamp: run-length meter
  // ---------------------------------------------------------------
  // a lamp only shows what it is driven with; lengths are in mclk cycles,
  // the first run after a state change is partial and gets overwritten
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prevLed <= 1'b0;
      runLen  <= 32'h0000_0001;
      hiLen   <= 32'h0000_0000;
      loLen   <= 32'h0000_0000;
      toggles <= 32'h0000_0000;
    end else if (errLed !== prevLed) begin
      if (prevLed) begin
        hiLen <= runLen;
      end else begin
        loLen <= runLen;
      end
      prevLed <= errLed;
      runLen  <= 32'h0000_0001;
      toggles <= toggles + 32'h0000_0001;
    end else begin
      runLen <= runLen + 32'h0000_0001;
    end
  end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import eles_pkg::*;
  // shortened millisecond so every blink fits in a short run
  localparam int unsigned MSC = 4;

  logic        mclk;
  logic        rst;
  logic        errValid;
  logic [15:0] errCode;
  logic        serious;
  logic        clearErr;
  logic        errLed;
  logic        cpuHalt;
  logic        runPermit;
  logic [2:0]  ledState;
  logic        unknownCode;
  logic [31:0] hiLen;
  logic [31:0] loLen;
  logic [31:0] toggles;
  int          failures;
  int          compares;

  eles_top #(.MS_CYCLES(MSC)) i_eles_top (
    .mclk(mclk), .rst(rst), .errValid(errValid), .errCode(errCode),
    .serious(serious), .clearErr(clearErr), .errLed(errLed), .cpuHalt(cpuHalt),
    .runPermit(runPermit), .ledState(ledState), .unknownCode(unknownCode)
  );
  eles_led_model i_eles_led_model (
    .mclk(mclk), .rst(rst), .errLed(errLed),
    .hiLen(hiLen), .loLen(loLen), .toggles(toggles)
  );

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic results;
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  // one-cycle request, then wait past the two-edge answer latency
  task automatic drive(input logic v, input logic [15:0] c, input logic s, input logic k);
    @(posedge mclk);
    errValid <= v;
    errCode  <= c;
    serious  <= s;
    clearErr <= k;
    @(posedge mclk);
    errValid <= 1'b0;
    serious  <= 1'b0;
    clearErr <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
  endtask

  task automatic send(input logic [15:0] c);
    drive(1'b1, c, 1'b0, 1'b0);
  endtask

  task automatic clr;
    drive(1'b0, 16'h0000, 1'b0, 1'b1);
  endtask

  task automatic status(input logic h, input logic p, input logic [2:0] st, input logic u);
    check({31'h0, cpuHalt}, {31'h0, h});
    check({31'h0, runPermit}, {31'h0, p});
    check({29'h0, ledState}, {29'h0, st});
    check({31'h0, unknownCode}, {31'h0, u});
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_halt_codes;
    logic [15:0] codes[10] = '{16'h000C, 16'h0010, 16'h002E, 16'h002F, 16'h0070,
                               16'h0102, 16'h0202, 16'h0302, 16'h0D03, 16'h0E05};
    foreach (codes[i]) begin
      send(codes[i]);
      status(1'b1, 1'b0, LED_NORMAL, 1'b0);
      clr();
      status(1'b0, 1'b1, LED_OFF, 1'b0);
    end
  endtask

  task automatic t_run_codes;
    logic [15:0] codes[$] = '{16'h0011, 16'h0012, 16'h002D, 16'h005D, 16'h005E,
                              16'h0063, 16'h0064, 16'h0026, 16'h0027};
    for (int i = 0; i < 10; i++) codes.push_back(16'h0050 + 16'(i));
    foreach (codes[i]) begin
      send(codes[i]);
      status(1'b0, 1'b1, LED_OFF, 1'b0);
      check({31'h0, errLed}, 32'h0);
    end
  endtask

  // lamp lengths are taken only after two full runs have passed
  task automatic t_blink(input logic [15:0] c, input logic h, input logic p,
                         input logic [2:0] st, input int unsigned hi, input int unsigned lo);
    logic [31:0] start;
    int          n;
    clr();
    send(c);
    status(h, p, st, 1'b0);
    start = toggles;
    n = 0;
    while (toggles < start + 32'd3 && n < 40000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n >= 40000) begin
      failures++;
      results();
    end else begin
      check(hiLen, hi);
      check(loLen, lo);
    end
  endtask

  task automatic t_severity;
    clr();
    send(16'h1300);
    status(1'b0, 1'b1, LED_SLOW, 1'b0);
    send(16'h0010);
    status(1'b1, 1'b0, LED_NORMAL, 1'b0);
    send(16'h1300);
    status(1'b1, 1'b0, LED_NORMAL, 1'b0);
    drive(1'b0, 16'h0000, 1'b1, 1'b0);
    status(1'b1, 1'b0, LED_ON, 1'b0);
    send(16'h002A);
    status(1'b1, 1'b0, LED_ON, 1'b0);
    check({31'h0, errLed}, 32'h1);
    clr();
    send(16'hFFFF);
    status(1'b0, 1'b1, LED_OFF, 1'b1);
    clr();
    // request in the same cycle as a clear is not lost
    drive(1'b1, 16'h0010, 1'b0, 1'b1);
    status(1'b1, 1'b0, LED_NORMAL, 1'b0);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    failures = 0;
    compares = 0;
    rst      = 1'b1;
    errValid = 1'b0;
    errCode  = 16'h0000;
    serious  = 1'b0;
    clearErr = 1'b0;
    repeat (6) @(posedge mclk);
    #1;
    status(1'b0, 1'b1, LED_OFF, 1'b0);
    check({31'h0, errLed}, 32'h0);
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    t_halt_codes();
    t_run_codes();
    t_blink(16'h002A, 1'b0, 1'b0, LED_FAST, FAST_HALF_MS * MSC, FAST_HALF_MS * MSC);
    t_blink(16'h0010, 1'b1, 1'b0, LED_NORMAL, NORMAL_HALF_MS * MSC, NORMAL_HALF_MS * MSC);
    t_blink(16'h130F, 1'b0, 1'b1, LED_SLOW, SLOW_ON_MS * MSC, SLOW_OFF_MS * MSC);
    t_severity();
    results();
  end
endmodule
`default_nettype wire
